//--- output_timing_ctrl.sv
// Soft reset, output enable and clock/pulse selection registers on the parallel CPU port
//
// Behaviour
// - Soft reset bit high holds switching reset
// - Soft reset bit low lets switching run
// - Pair enable high drives clock and pulse
// - Pair enable low floats clock and pulse
// - Offset enable high drives offset pulse
// - Offset enable low floats offset pulse
`timescale 1ns/1ps
`default_nettype none

module output_timing_ctrl
	import output_timing_pkg::*;
#(
	parameter int PAIRS = 4,
	parameter int OFFSETS = 3
) (
	input wire logic clock,
	input wire logic reset,
	input wire cpu_port_t cpu_in,
	output logic [`DATA_WIDTH-1:0] cpu_data_out,
	output logic cpu_data_oe_n,
	input wire logic [PAIRS-2:0] pair_clock_in,
	input wire logic [PAIRS-2:0] pair_frame_in,
	input wire rate_timing_t rate_in,
	input wire logic [OFFSETS-1:0] offset_pulse_in,
	output logic switch_soft_reset,
	output logic [PAIRS-1:0] reference_clock_out,
	output logic [PAIRS-1:0] reference_clock_oe_n,
	output logic [PAIRS-1:0] frame_pulse_out,
	output logic [PAIRS-1:0] frame_pulse_oe_n,
	output logic [OFFSETS-1:0] offset_frame_pulse_out,
	output logic [OFFSETS-1:0] offset_frame_pulse_oe_n
);

	localparam cpu_port_t CPU_IDLE = '{cs_n: 1'b1, ds_n: 1'b1, rw: 1'b1, addr: '0, data: '0};

	cpu_port_t cpu_sync;
	logic strobe_prev_reg;
	logic [`DATA_WIDTH-1:0] soft_reset_reg;
	logic [`DATA_WIDTH-1:0] enable_reg;
	logic [`DATA_WIDTH-1:0] select_reg;

	// Bit of one pair's polarity or position field
	function automatic logic pair_bit(input logic [`DATA_WIDTH-1:0] sel, input int pair,
		input int ofs);
		pair_bit = sel[pair * `PAIR_FIELD_STRIDE + ofs];
	endfunction : pair_bit

	// Pins cross into the clock domain before decode
	pin_sync #(
		.WIDTH($bits(cpu_port_t))
	) cpu_pin_sync (
		.clock(clock),
		.reset(reset),
		.pin_in(cpu_in),
		.reset_value(CPU_IDLE),
		.sync_out(cpu_sync)
	);

	wire selected = ~cpu_sync.cs_n & ~cpu_sync.ds_n;
	wire strobe_fall = strobe_prev_reg & selected;
	wire write_strobe = strobe_fall & ~cpu_sync.rw;
	wire hit_reset = cpu_sync.addr == `SOFT_RESET_ADDR;
	wire hit_enable = cpu_sync.addr == `CLOCK_PULSE_ENABLE_ADDR;
	wire hit_select = cpu_sync.addr == `CLOCK_PULSE_SELECT_ADDR;
	wire hit_any = hit_reset | hit_enable | hit_select;
	wire read_active = selected & cpu_sync.rw & hit_any;
	// Reserved bits are left unstored, so they read back as zero
	wire [`DATA_WIDTH-1:0] reset_next = cpu_sync.data & `SOFT_RESET_MASK;
	wire [`DATA_WIDTH-1:0] enable_next = cpu_sync.data & `CLOCK_PULSE_ENABLE_MASK;
	wire [`DATA_WIDTH-1:0] select_next = cpu_sync.data & `CLOCK_PULSE_SELECT_MASK;
	wire [`DATA_WIDTH-1:0] read_next = hit_reset ? soft_reset_reg :
		hit_enable ? enable_reg :
		hit_select ? select_reg : '0;
	wire rate_sel_t rate_sel = rate_sel_t'(select_reg[`SELECT_FIELD_LSB +: 2]);
	wire pair3_clock = rate_in.clock[rate_sel];
	wire pair3_frame = rate_in.frame[rate_sel];
	wire [PAIRS-1:0] src_clock = {pair3_clock, pair_clock_in};
	wire [PAIRS-1:0] src_frame = {pair3_frame, pair_frame_in};

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			strobe_prev_reg <= 1'b0;
			soft_reset_reg <= `SOFT_RESET_RESET;
			enable_reg <= `CLOCK_PULSE_ENABLE_RESET;
			select_reg <= `CLOCK_PULSE_SELECT_RESET;
			cpu_data_out <= 16'h0000;
			cpu_data_oe_n <= 1'b1;
		end
		else
		begin
			strobe_prev_reg <= ~selected;
			if (write_strobe && hit_reset)
				soft_reset_reg <= reset_next;
			if (write_strobe && hit_enable)
				enable_reg <= enable_next;
			if (write_strobe && hit_select)
				select_reg <= select_next;
			cpu_data_out <= read_active ? read_next : 16'h0000;
			cpu_data_oe_n <= ~read_active;
		end
	end

	// Switching blocks are held only while the bit stays high
	always_ff @(posedge clock)
	begin
		if (reset)
			switch_soft_reset <= 1'b0;
		else
			switch_soft_reset <= soft_reset_reg[`SOFT_RESET_BIT];
	end

	genvar p;
	generate
		for (p = 0; p < PAIRS; p++)
		begin : pair_gen
			wire enabled = enable_reg[`REF_PAIR_ENABLE_LSB + p];
			wire clock_inv = pair_bit(select_reg, p, `CLOCK_POLARITY_OFS);
			wire frame_inv = pair_bit(select_reg, p, `FRAME_POLARITY_OFS);
			always_ff @(posedge clock)
			begin
				if (reset)
				begin
					reference_clock_out[p] <= 1'b0;
					frame_pulse_out[p] <= 1'b0;
					reference_clock_oe_n[p] <= 1'b1;
					frame_pulse_oe_n[p] <= 1'b1;
				end
				else
				begin
					// Polarity bits invert; position needs the frame counter outside
					reference_clock_out[p] <= src_clock[p] ^ clock_inv;
					frame_pulse_out[p] <= src_frame[p] ^ frame_inv;
					reference_clock_oe_n[p] <= ~enabled;
					frame_pulse_oe_n[p] <= ~enabled;
				end
			end
		end
		for (p = 0; p < OFFSETS; p++)
		begin : offset_gen
			always_ff @(posedge clock)
			begin
				if (reset)
				begin
					offset_frame_pulse_out[p] <= 1'b0;
					offset_frame_pulse_oe_n[p] <= 1'b1;
				end
				else
				begin
					offset_frame_pulse_out[p] <= offset_pulse_in[p];
					offset_frame_pulse_oe_n[p] <= ~enable_reg[`OFFSET_ENABLE_LSB + p];
				end
			end
		end
	endgenerate

	soft_reset_set_a: assert property (@(posedge clock) disable iff (reset)
		write_strobe && hit_reset && cpu_sync.data[1] |=> ##1 switch_soft_reset)
		else $error("soft reset not raised after write");

	soft_reset_clear_a: assert property (@(posedge clock) disable iff (reset)
		write_strobe && hit_reset && !cpu_sync.data[1] |=> ##1 !switch_soft_reset)
		else $error("soft reset not released after write");

	reserved_zero_a: assert property (@(posedge clock) disable iff (reset)
		(soft_reset_reg & ~`SOFT_RESET_MASK) == 16'h0000
		&& (enable_reg & ~`CLOCK_PULSE_ENABLE_MASK) == 16'h0000
		&& (select_reg & ~`CLOCK_PULSE_SELECT_MASK) == 16'h0000)
		else $error("reserved bits stored");

	pair_drive_a: assert property (@(posedge clock) disable iff (reset)
		write_strobe && hit_enable && cpu_sync.data[3] |=> ##1
		!reference_clock_oe_n[3] && !frame_pulse_oe_n[3])
		else $error("pair three not driven after enable");

	pair_float_a: assert property (@(posedge clock) disable iff (reset)
		write_strobe && hit_enable && !cpu_sync.data[0] |=> ##1
		reference_clock_oe_n[0] && frame_pulse_oe_n[0])
		else $error("pair zero still driven after disable");

	offset_drive_a: assert property (@(posedge clock) disable iff (reset)
		write_strobe && hit_enable && cpu_sync.data[7] |=> ##1 !offset_frame_pulse_oe_n[1])
		else $error("offset pulse one not driven");

	offset_float_a: assert property (@(posedge clock) disable iff (reset)
		$fell(enable_reg[6]) |=> offset_frame_pulse_oe_n[0])
		else $error("offset pulse zero still driven");

	rate_select_a: assert property (@(posedge clock) disable iff (reset)
		select_reg[13:12] == 2'b11 && !select_reg[10] && $stable(select_reg)
		|=> frame_pulse_out[3] == $past(rate_in.frame[3]))
		else $error("pair three pulse not from selected rate");

	read_back_a: assert property (@(posedge clock) disable iff (reset)
		selected && cpu_sync.rw && hit_enable |=> !cpu_data_oe_n
		&& cpu_data_out == $past(enable_reg))
		else $error("enable register read back wrong");

	soft_reset_read_a: assert property (@(posedge clock) disable iff (reset)
		selected && cpu_sync.rw && hit_reset |=> !cpu_data_oe_n
		&& cpu_data_out == $past(soft_reset_reg))
		else $error("soft reset register read back wrong");

	// Unmapped addresses neither answer nor store
	unmapped_read_a: assert property (@(posedge clock) disable iff (reset)
		selected && cpu_sync.rw && !hit_any |=> cpu_data_oe_n)
		else $error("unmapped address answered");

	unmapped_write_a: assert property (@(posedge clock) disable iff (reset)
		write_strobe && !hit_any |=> $stable(soft_reset_reg) && $stable(enable_reg)
		&& $stable(select_reg))
		else $error("unmapped write stored");

	offset_far_drive_a: assert property (@(posedge clock) disable iff (reset)
		write_strobe && hit_enable && cpu_sync.data[8] |=> ##1 !offset_frame_pulse_oe_n[2])
		else $error("offset pulse two not driven");

	offset_mid_float_a: assert property (@(posedge clock) disable iff (reset)
		write_strobe && hit_enable && !cpu_sync.data[7] |=> ##1 offset_frame_pulse_oe_n[1])
		else $error("offset pulse one still driven");

	// Polarity bit inverts the selected source, one cycle late
	clock_polarity_a: assert property (@(posedge clock) disable iff (reset)
		select_reg[11] && $stable(select_reg)
		|=> reference_clock_out[3] != $past(pair3_clock))
		else $error("pair three clock not inverted");

	frame_polarity_a: assert property (@(posedge clock) disable iff (reset)
		select_reg[1] && $stable(select_reg)
		|=> frame_pulse_out[0] != $past(pair_frame_in[0]))
		else $error("pair zero pulse not inverted");

endmodule : output_timing_ctrl

`default_nettype wire

//--- output_timing_defines.svh
// Register offsets, field positions and reset values of the output timing control block
`ifndef OUTPUT_TIMING_DEFINES_SVH
`define OUTPUT_TIMING_DEFINES_SVH

`define ADDR_WIDTH 14
`define DATA_WIDTH 16

`define SOFT_RESET_ADDR 14'h0002
`define CLOCK_PULSE_ENABLE_ADDR 14'h0003
`define CLOCK_PULSE_SELECT_ADDR 14'h0004

`define SOFT_RESET_BIT 1
`define REF_PAIR_ENABLE_LSB 0
`define OFFSET_ENABLE_LSB 6
`define SELECT_FIELD_LSB 12
`define PAIR_FIELD_STRIDE 3
`define CLOCK_POLARITY_OFS 2
`define FRAME_POLARITY_OFS 1
`define FRAME_POSITION_OFS 0

`define SOFT_RESET_RESET 16'h0000
`define CLOCK_PULSE_ENABLE_RESET 16'h0000
`define CLOCK_PULSE_SELECT_RESET 16'h0000

`define SOFT_RESET_MASK 16'h0002
`define CLOCK_PULSE_ENABLE_MASK 16'h01CF
`define CLOCK_PULSE_SELECT_MASK 16'h3FFF

`endif

//--- output_timing_pkg.sv
// Types shared by the output timing control block
`default_nettype none
`include "output_timing_defines.svh"

package output_timing_pkg;

	typedef struct packed {
		logic cs_n;
		logic ds_n;
		logic rw;
		logic [`ADDR_WIDTH-1:0] addr;
		logic [`DATA_WIDTH-1:0] data;
	} cpu_port_t;

	typedef struct packed {
		logic [3:0] clock;
		logic [3:0] frame;
	} rate_timing_t;

	typedef enum logic [1:0] {
		RATE_4M,
		RATE_8M,
		RATE_16M,
		RATE_32M
	} rate_sel_t;

endpackage : output_timing_pkg

`default_nettype wire

//--- pin_sync.sv
// Two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic [WIDTH-1:0] pin_in,
	input wire logic [WIDTH-1:0] reset_value,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] first_reg;

	// The first stage feeds only the second
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			first_reg <= reset_value;
			sync_out <= reset_value;
		end
		else
		begin
			first_reg <= pin_in;
			sync_out <= first_reg;
		end
	end

endmodule : pin_sync

`default_nettype wire

//--- tdm_downstream.sv
// Downstream device model: resolves the timing output pins
`timescale 1ns/1ps
`default_nettype none

module tdm_downstream (
	input wire logic clock,
	input wire logic [10:0] value,
	input wire logic [10:0] oe_n,
	output logic [10:0] pin
);
	logic [10:0] last_reg = 11'h000;

	// A floating pin toggles, so a stale level never passes for a driven one
	assign pin = (value & ~oe_n) | (~last_reg & oe_n);

	always_ff @(posedge clock)
		last_reg <= pin;
endmodule : tdm_downstream

`default_nettype wire

//--- testbench.sv
// Self-checking testbench of the output timing control block
`timescale 1ns/1ps
`default_nettype none

module testbench
	import output_timing_pkg::*;
;
	logic clock = 1'b0;
	logic reset = 1'b1;
	cpu_port_t cpu_in;
	rate_timing_t rate_in;
	logic [15:0] rd_data;
	logic rd_oe_n, swr;
	logic [2:0] pclk, pfrm, opulse, ofo, ofoe;
	logic [3:0] rco, rcoe, fpo, fpoe;
	logic [10:0] pins;
	int fails = 0;
	int comparisons = 0;

	always #2.5 clock = ~clock;

	output_timing_ctrl i_dut (.clock(clock), .reset(reset), .cpu_in(cpu_in),
		.cpu_data_out(rd_data), .cpu_data_oe_n(rd_oe_n), .pair_clock_in(pclk),
		.pair_frame_in(pfrm), .rate_in(rate_in), .offset_pulse_in(opulse),
		.switch_soft_reset(swr), .reference_clock_out(rco), .reference_clock_oe_n(rcoe),
		.frame_pulse_out(fpo), .frame_pulse_oe_n(fpoe), .offset_frame_pulse_out(ofo),
		.offset_frame_pulse_oe_n(ofoe));

	tdm_downstream i_far (.clock(clock), .value({ofo, fpo, rco}), .oe_n({ofoe, fpoe, rcoe}),
		.pin(pins));

	task step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : step

	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// Read when r is high: d is the expected word, mapped says the block answers
	task acc(input logic r, input logic [13:0] a, input logic [15:0] d, input logic mapped);
		cpu_in = '{cs_n: 1'b1, ds_n: 1'b1, rw: r, addr: a, data: r ? 16'h0000 : d};
		step(3);
		cpu_in.cs_n = 1'b0;
		cpu_in.ds_n = 1'b0;
		step(5);
		if (r)
			chk({rd_oe_n, rd_data}, {!mapped, mapped ? d : 16'h0000}, "read");
		cpu_in.cs_n = 1'b1;
		cpu_in.ds_n = 1'b1;
		step(5);
		if (r)
			chk({rd_oe_n, rd_data}, {1'b1, 16'h0000}, "read release");
	endtask : acc

	task test_reset;
		for (int a = 2; a < 5; a++)
			acc(1'b1, 14'(a), 16'h0000, 1'b1);
		chk({swr, rcoe, fpoe, ofoe}, {1'b0, 4'hF, 4'hF, 3'h7}, "reset outputs");
		$display("test reset done");
	endtask : test_reset

	task test_soft;
		acc(1'b0, 14'h0002, 16'h0002, 1'b1);
		chk(swr, 1'b1, "soft reset set");
		acc(1'b1, 14'h0002, 16'h0002, 1'b1);
		acc(1'b0, 14'h0002, 16'h0000, 1'b1);
		chk(swr, 1'b0, "soft reset clear");
		$display("test soft done");
	endtask : test_soft

	task test_enable;
		for (int i = 0; i < 4; i++)
		begin
			acc(1'b0, 14'h0003, 16'h0001 << i, 1'b1);
			chk({rcoe, fpoe}, {~(4'h1 << i), ~(4'h1 << i)}, "pair oe");
			chk({pins[i], pins[4+i]}, i < 3 ? {pclk[i], pfrm[i]} : {rate_in.clock[0],
				rate_in.frame[0]}, "pair pins");
		end
		for (int j = 0; j < 3; j++)
		begin
			acc(1'b0, 14'h0003, 16'h0040 << j, 1'b1);
			chk({ofoe, rcoe}, {~(3'h1 << j), 4'hF}, "offset oe");
			chk(pins[8+j], opulse[j], "offset pin");
		end
		$display("test enable done");
	endtask : test_enable

	task test_select;
		acc(1'b0, 14'h0003, 16'h0008, 1'b1);
		for (int c = 0; c < 4; c++)
		begin
			acc(1'b0, 14'h0004, 16'(c << 12), 1'b1);
			chk({pins[3], pins[7]}, {rate_in.clock[c], rate_in.frame[c]}, "rate");
			acc(1'b1, 14'h0004, 16'(c << 12), 1'b1);
		end
		acc(1'b0, 14'h0003, 16'h0009, 1'b1);
		acc(1'b0, 14'h0004, 16'h3C06, 1'b1);
		chk({pins[3], pins[7], pins[0], pins[4]}, {~rate_in.clock[3], ~rate_in.frame[3],
			~pclk[0], ~pfrm[0]}, "polarity");
		acc(1'b1, 14'h0004, 16'h3C06, 1'b1);
		$display("test select done");
	endtask : test_select

	task test_unmapped;
		acc(1'b0, 14'h0005, 16'hFFFF, 1'b0);
		acc(1'b1, 14'h0005, 16'h0000, 1'b0);
		acc(1'b1, 14'h0003, 16'h0009, 1'b1);
		$display("test unmapped done");
	endtask : test_unmapped

	// Reset in mid-run must clear every register and float every pin
	task test_rerun;
		acc(1'b0, 14'h0002, 16'h0002, 1'b1);
		chk(swr, 1'b1, "rerun soft reset set");
		reset = 1'b1;
		step(4);
		reset = 1'b0;
		chk({swr, rcoe, fpoe, ofoe, rd_oe_n}, {1'b0, 4'hF, 4'hF, 3'h7, 1'b1}, "rerun outputs");
		for (int a = 2; a < 5; a++)
			acc(1'b1, 14'(a), 16'h0000, 1'b1);
		$display("test rerun done");
	endtask : test_rerun

	task conclude;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude

	initial
	begin
		cpu_in = '{cs_n: 1'b1, ds_n: 1'b1, rw: 1'b1, addr: 14'h0000, data: 16'h0000};
		rate_in = '{clock: 4'h6, frame: 4'hA};
		pclk = 3'h5;
		pfrm = 3'h3;
		opulse = 3'h5;
		step(12);
		reset = 1'b0;
		test_reset();
		test_soft();
		test_enable();
		test_select();
		test_unmapped();
		test_rerun();
		conclude();
	end

	// Run needs well under a thousand cycles
	initial
	begin
		#25000;
		fails++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		conclude();
	end
endmodule : testbench

`default_nettype wire
